// File: sae_tx.v
// Serial altitude sentence builder and 8N1 transmitter
`timescale 1ns/1ns
`default_nettype none
`include "sae_defines.vh"
module sae_tx #(
    parameter [14:0] DIV_FMT12 = `SAE_DIV_FMT12,
    parameter [14:0] DIV_FMT3 = `SAE_DIV_FMT3,
    parameter [14:0] DIV_FMT4 = `SAE_DIV_FMT4
) (
    input wire sys_clk,
    input wire rst,
    input wire [17:0] pressure_alt,
    input wire [1:0] sentence_format_select,
    input wire res_100ft,
    input wire send_req,
    output wire busy,
    output wire enc_tx
);
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_CONV = 4'h2;
    localparam [3:0] ST_EMIT = 4'h4;
    localparam [3:0] ST_DRAIN = 4'h8;

    function [7:0] hex_char;
        input [3:0] nib;
        begin
            hex_char = (nib < 4'hA) ? {4'h3, nib} : (8'h37 + {4'h0, nib});
        end
    endfunction

    function [16:0] pow10;
        input [2:0] p;
        begin
            case (p)
                3'h0: pow10 = 17'h00001;
                3'h1: pow10 = 17'h0000A;
                3'h2: pow10 = 17'h00064;
                3'h3: pow10 = 17'h003E8;
                default: pow10 = 17'h02710;
            endcase
        end
    endfunction

    function [7:0] sentence_byte;
        input [1:0] fmt;
        input [4:0] idx;
        input neg;
        input [19:0] dig;
        input [7:0] cks;
        reg [7:0] sign_ch;
        reg [4:0] dpos;
        begin
            sign_ch = neg ? 8'h2D : 8'h2B;
            sentence_byte = 8'h0D;
            dpos = 5'h0;
            if (fmt == `SAE_FMT_ONE || fmt == `SAE_FMT_TWO) begin
                dpos = idx - 5'h05;
                case (idx)
                    5'h00: sentence_byte = (fmt == `SAE_FMT_ONE) ? 8'h23 : 8'h24;
                    5'h01: sentence_byte = (fmt == `SAE_FMT_ONE) ? 8'h41 : 8'h4D;
                    5'h02: sentence_byte = (fmt == `SAE_FMT_ONE) ? 8'h4C : 8'h47;
                    5'h03: sentence_byte = (fmt == `SAE_FMT_ONE) ? 8'h20 : 8'h4C;
                    5'h04: sentence_byte = sign_ch;
                    5'h05, 5'h06, 5'h07, 5'h08, 5'h09:
                        sentence_byte = {4'h3, dig[(5'h04 - dpos)*4 +: 4]};
                    5'h0A: sentence_byte = 8'h54;
                    5'h0B: sentence_byte = 8'h2B;
                    5'h0C: sentence_byte = 8'h32;
                    5'h0D: sentence_byte = 8'h35;
                    5'h0E: sentence_byte = hex_char(cks[7:4]);
                    5'h0F: sentence_byte = hex_char(cks[3:0]);
                    default: sentence_byte = 8'h0D;
                endcase
            end else begin
                dpos = idx - 5'h04;
                case (idx)
                    5'h00: sentence_byte = 8'h41;
                    5'h01: sentence_byte = 8'h4C;
                    5'h02: sentence_byte = 8'h54;
                    5'h03: sentence_byte = 8'h20;
                    5'h04: sentence_byte = neg ? 8'h2D : {4'h3, dig[19:16]};
                    5'h05, 5'h06, 5'h07, 5'h08:
                        sentence_byte = {4'h3, dig[(5'h04 - dpos)*4 +: 4]};
                    default: sentence_byte = 8'h0D;
                endcase
            end
        end
    endfunction

    reg [3:0] state;
    reg [1:0] fmt;
    reg res100;
    reg neg;
    reg [16:0] rem;
    reg [2:0] dpos;
    reg [19:0] digits;
    reg [4:0] idx;
    reg [7:0] cks;
    reg [14:0] div_sel;
    reg tx_act;
    reg [9:0] shreg;
    reg [3:0] bitcnt;
    reg [14:0] bcnt;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [7:0] fifo_out_data;
    wire [19:0] q_digits;
    wire [7:0] cur_byte;
    wire [4:0] last_idx;
    wire [17:0] mag;

    // Resolution masks low digits
    assign q_digits = {digits[19:8], res100 ? 4'h0 : digits[7:4], 4'h0};
    assign cur_byte = sentence_byte(fmt, idx, neg, q_digits, cks);
    assign last_idx = (fmt == `SAE_FMT_ONE || fmt == `SAE_FMT_TWO) ?
        `SAE_LAST_IDX_LONG : `SAE_LAST_IDX_SHORT;
    // Input is already referenced to 29.92, no baro term here
    assign mag = pressure_alt[17] ? (~pressure_alt + 18'h00001) : pressure_alt;
    assign busy = (state != ST_IDLE);
    assign enc_tx = shreg[0];

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            fmt <= `SAE_FMT_ONE;
            res100 <= 1'b0;
            neg <= 1'b0;
            rem <= 17'h00000;
            dpos <= 3'h0;
            digits <= 20'h00000;
            idx <= 5'h00;
            cks <= 8'h00;
            div_sel <= 15'h0001;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (send_req) begin
                        fmt <= sentence_format_select;
                        res100 <= res_100ft;
                        neg <= pressure_alt[17];
                        rem <= (mag > {1'b0, `SAE_ALT_MAX}) ? `SAE_ALT_MAX : mag[16:0];
                        dpos <= 3'h4;
                        digits <= 20'h00000;
                        idx <= 5'h00;
                        cks <= 8'h00;
                        case (sentence_format_select)
                            `SAE_FMT_THREE: div_sel <= DIV_FMT3;
                            `SAE_FMT_FOUR: div_sel <= DIV_FMT4;
                            default: div_sel <= DIV_FMT12;
                        endcase
                        state <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    // Decimal digits by repeated subtraction, zero padded
                    if (rem >= pow10(dpos)) begin
                        rem <= rem - pow10(dpos);
                        digits[dpos*4 +: 4] <= digits[dpos*4 +: 4] + 4'h1;
                    end else if (dpos == 3'h0) begin
                        state <= ST_EMIT;
                    end else begin
                        dpos <= dpos - 3'h1;
                    end
                end
                ST_EMIT: begin
                    if (fifo_in_ready) begin
                        if (idx < `SAE_CKS_HI_IDX) begin
                            cks <= cks + cur_byte;
                        end
                        if (idx == last_idx) begin
                            state <= ST_DRAIN;
                        end else begin
                            idx <= idx + 5'h01;
                        end
                    end
                end
                ST_DRAIN: begin
                    // Hold rate until the last bit has left the line
                    if (!fifo_out_valid && !tx_act) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    sae_fifo #(
        .WIDTH(`SAE_FIFO_WIDTH),
        .DEPTH(`SAE_FIFO_DEPTH),
        .AW(`SAE_FIFO_AW)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_valid(state == ST_EMIT),
        .in_ready(fifo_in_ready),
        .in_data(cur_byte),
        .out_valid(fifo_out_valid),
        .out_ready(!tx_act),
        .out_data(fifo_out_data)
    );

    // 8N1 shifter, start bit low, stop bit high
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tx_act <= 1'b0;
            shreg <= 10'h3FF;
            bitcnt <= 4'h0;
            bcnt <= 15'h0000;
        end else if (!tx_act) begin
            if (fifo_out_valid) begin
                shreg <= {1'b1, fifo_out_data, 1'b0};
                bitcnt <= 4'h0;
                bcnt <= div_sel - 15'h0001;
                tx_act <= 1'b1;
            end
        end else if (bcnt == 15'h0000) begin
            bcnt <= div_sel - 15'h0001;
            shreg <= {1'b1, shreg[9:1]};
            if (bitcnt == `SAE_FRAME_BITS) begin
                tx_act <= 1'b0;
            end else begin
                bitcnt <= bitcnt + 4'h1;
            end
        end else begin
            bcnt <= bcnt - 15'h0001;
        end
    end
endmodule // sae_tx
`default_nettype wire

// File: sae_defines.vh
// Constants for the serial altitude encoder transmitter
`ifndef SAE_DEFINES_VH
`define SAE_DEFINES_VH

`define SAE_CLK_HZ 20000000
`define SAE_BAUD_FMT12 1200
`define SAE_BAUD_FMT3 2400
`define SAE_BAUD_FMT4 9600
`define SAE_DIV_FMT12 15'h411B
`define SAE_DIV_FMT3 15'h208D
`define SAE_DIV_FMT4 15'h0823

`define SAE_FMT_ONE 2'h0
`define SAE_FMT_TWO 2'h1
`define SAE_FMT_THREE 2'h2
`define SAE_FMT_FOUR 2'h3

`define SAE_LAST_IDX_LONG 5'h10
`define SAE_LAST_IDX_SHORT 5'h09
`define SAE_CKS_HI_IDX 5'h0E
`define SAE_ALT_MAX 17'h1869F

`define SAE_FRAME_BITS 4'h9
`define SAE_FIFO_WIDTH 8
`define SAE_FIFO_DEPTH 8
`define SAE_FIFO_AW 3

`endif

// File: sae_fifo.v
// Byte FIFO between sentence builder and serial shifter
`timescale 1ns/1ns
`default_nettype none
module sae_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire sys_clk,
    input wire rst,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push;
    wire pop;

    assign in_ready = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    always @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // sae_fifo
`default_nettype wire

// File: sae_rx_model.sv
// Serial receiver model standing in for the transponder input
`timescale 1ns/1ns
`default_nettype none
module sae_rx_model (
    input wire logic sys_clk,
    input wire logic ser_in,
    input wire logic [15:0] div,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic frame_err
);
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        frame_err = 1'b0;
        forever begin
            @(negedge ser_in);
            repeat (div / 2) @(posedge sys_clk);
            frame_err = ser_in;
            for (int i = 0; i < 8; i++) begin
                repeat (div) @(posedge sys_clk);
                rx_data[i] = ser_in;
            end
            repeat (div) @(posedge sys_clk);
            frame_err = frame_err | !ser_in;
            rx_valid = 1'b1;
            @(posedge sys_clk);
            rx_valid = 1'b0;
        end
    end
endmodule // sae_rx_model
`default_nettype wire

// File: sae_tx_properties.sv
// Port checks for the altitude sentence transmitter
`timescale 1ns/1ns
`default_nettype none
module sae_tx_properties #(
    parameter [14:0] DIV_FMT12 = 15'h4,
    parameter [14:0] DIV_FMT3 = 15'h4,
    parameter [14:0] DIV_FMT4 = 15'h2
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [1:0] sentence_format_select,
    input wire logic send_req,
    input wire logic busy,
    input wire logic enc_tx
);
    logic [15:0] run;
    logic [1:0] fmt;
    logic prev;
    logic [15:0] d;
    assign d = fmt == 2'h3 ? {1'b0, DIV_FMT4} : fmt == 2'h2 ? {1'b0, DIV_FMT3} : {1'b0, DIV_FMT12};
    // Length of the current line level
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            run <= 16'h0;
            prev <= 1'b1;
            fmt <= 2'h0;
        end else begin
            prev <= enc_tx;
            run <= enc_tx != prev ? 16'h1 : run + 16'h1;
            if (send_req && !busy) fmt <= sentence_format_select;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_idle_line_high: assert property (!busy |-> enc_tx)
        else $error("line low while idle");
    a_accept_busy: assert property (send_req && !busy |=> busy)
        else $error("request not taken");
    a_start_soon: assert property ($rose(busy) |-> ##[1:80] !enc_tx)
        else $error("no start bit");
    a_busy_span: assert property ($rose(busy) |-> busy [*8])
        else $error("busy too short");
    a_bit_time: assert property (busy && enc_tx && !prev |-> run != 16'h0 && run % d == 16'h0)
        else $error("bit time off");
    a_stop_done: assert property ($fell(busy) |-> enc_tx && run >= d)
        else $error("stop bit cut");
    a_reset_idle: assert property ($fell(rst) |-> enc_tx && !busy)
        else $error("not idle after reset");
    c_fmt_four: cover property (send_req && !busy && sentence_format_select == 2'h3);
    c_refused: cover property (send_req && busy);
    c_done: cover property ($fell(busy));
endmodule // sae_tx_properties
bind sae_tx sae_tx_properties #(.DIV_FMT12(DIV_FMT12), .DIV_FMT3(DIV_FMT3), .DIV_FMT4(DIV_FMT4))
    sae_tx_properties_i (.sys_clk(sys_clk), .rst(rst), .send_req(send_req),
    .sentence_format_select(sentence_format_select), .busy(busy), .enc_tx(enc_tx));
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the altitude sentence transmitter
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [17:0] pressure_alt = 18'h0;
    logic [1:0] sentence_format_select = 2'h0;
    logic res_100ft = 1'b0;
    logic send_req = 1'b0;
    logic [15:0] div = 16'h8;
    wire logic busy, enc_tx, rx_valid, frame_err;
    wire logic [7:0] rx_data;
    logic [7:0] exp_q[$];
    logic [17:0] a;
    int fail_count = 0;
    int tests_run = 0;
    int cyc = 0;
    int seed = 32'h80E9;
    always #25 sys_clk = ~sys_clk;
    sae_tx #(.DIV_FMT12(15'h8), .DIV_FMT3(15'h6), .DIV_FMT4(15'h4)) sae_tx_i (
        .sys_clk(sys_clk), .rst(rst), .pressure_alt(pressure_alt), .res_100ft(res_100ft),
        .sentence_format_select(sentence_format_select), .send_req(send_req),
        .busy(busy), .enc_tx(enc_tx));
    sae_rx_model sae_rx_model_i (.sys_clk(sys_clk), .ser_in(enc_tx), .div(div),
        .rx_valid(rx_valid), .rx_data(rx_data), .frame_err(frame_err));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string n);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    function automatic logic [7:0] hx(input logic [3:0] v);
        return v < 4'hA ? 8'h30 + v : 8'h37 + v;
    endfunction
    // Builds the expected sentence, then requests it
    task automatic send(input int i, input logic [17:0] al);
        int m;
        logic [1:0] f;
        logic [7:0] c;
        logic [7:0] s[$];
        string h;
        f = i[1:0];
        m = al[17] ? 262144 - al : al;
        if (m > 99999) m = 99999;
        m = m - m % (i[2] ? 100 : 10);
        h = f == 2'h0 ? "#AL " : f == 2'h1 ? "$MGL" : "ALT ";
        for (int k = 0; k < 4; k++) s.push_back(h[k]);
        if (f < 2'h2) s.push_back(al[17] ? "-" : "+");
        for (int k = 10000; k > 0; k /= 10) s.push_back(8'(8'h30 + m / k % 10));
        if (f > 2'h1 && al[17]) s[4] = "-";
        if (f < 2'h2) begin
            h = "T+25";
            for (int k = 0; k < 4; k++) s.push_back(h[k]);
            c = 8'h00;
            foreach (s[k]) c += s[k];
            s.push_back(hx(c[7:4]));
            s.push_back(hx(c[3:0]));
        end
        s.push_back(8'h0D);
        foreach (s[k]) exp_q.push_back(s[k]);
        do @(negedge sys_clk); while (busy !== 1'b0);
        @(posedge sys_clk);
        div <= f == 2'h3 ? 16'h4 : f == 2'h2 ? 16'h6 : 16'h8;
        sentence_format_select <= f;
        pressure_alt <= al;
        res_100ft <= i[2];
        send_req <= 1'b1;
        @(posedge sys_clk);
        send_req <= 1'b0;
        @(negedge sys_clk);
        chk(busy, 1, "busy");
        if (i == 5) begin
            repeat (30) @(posedge sys_clk);
            sentence_format_select <= ~f;
            send_req <= 1'b1;
            @(posedge sys_clk);
            send_req <= 1'b0;
        end
    endtask
    always @(posedge rx_valid) begin
        chk(frame_err, 0, "frame");
        chk(rx_data, exp_q.size() ? exp_q.pop_front() : 9'h100, "rx_byte");
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 40000) begin
            fail_count++;
            report_and_stop;
        end
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        @(negedge sys_clk);
        chk(enc_tx, 1, "idle_line");
        for (int i = 0; i < 12; i++) begin
            a = 18'($random(seed));
            if (i > 7) a = i[0] ? 18'h1FFFF : 18'h3FB2E;
            send(i, a);
        end
        do @(negedge sys_clk); while (busy !== 1'b0);
        repeat (20) @(posedge sys_clk);
        chk(exp_q.size(), 0, "leftover");
        report_and_stop;
    end
endmodule // testbench
`default_nettype wire
